// >>> core/mq_fifo_pkg.sv
// Constants shared by the multi-queue flag, retransmit and configuration logic.
package mq_fifo_pkg;

  // Queue organisation.
  localparam int NUM_QUEUES = 8;
  localparam int QSEL_W = 3;
  localparam int QUEUE_DEPTH = 16;
  localparam int DATA_W = 36;

  // Words held back below the full boundary to absorb the late full flag.
  localparam int FULL_GUARD_WORDS = 4;
  // Reads that take a full queue back to a clear flag, counted in words.
  localparam int FULL_CLEAR_WORDS = 2;
  // Cycles between empty asserting and the frozen full limit being released.
  localparam int FULL_LIMIT_RELEASE_DELAY = 4;
  localparam int RELEASE_CNT_W = 8;

  // Configuration register file.
  localparam int CFG_COUNT = 10;
  localparam int CFG_W = 8;
  localparam int CFG_IDX_W = 4;
  localparam logic [3:0] CFG_ADDR_FIRST = 4'h1;
  localparam logic [3:0] CFG_ADDR_LAST = 4'hA;
  localparam logic [3:0] CFG_IDX_LAST = 4'h9;
  localparam logic [3:0] CFG_QCOUNT_IDX = 4'h2;
  localparam logic [3:0] CFG_FAST_IDX = 4'h9;
  localparam int QCOUNT_BIT0 = 0;
  localparam int QCOUNT_BIT1 = 1;
  localparam int QCOUNT_BIT2 = 2;
  localparam int FAST_CLK_BIT = 7;
  localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
    8'h00, 8'h00, 8'h07, 8'h7F, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h80
  };
  localparam logic [2:0] QCOUNT_RESET = 3'h7;

  // Configuration changes reach the queue logic this many clock edges late.
  localparam int CFG_APPLY_CYCLES = 8;
  localparam int APPLY_CNT_W = 4;

  // Serial load framing: command byte, address byte, data byte, MSB first.
  localparam logic [7:0] SER_WRITE_CMD = 8'h02;
  localparam int SER_FRAME_BITS = 24;
  localparam int SER_CNT_W = 5;

endpackage

// >>> core/multi_queue_fifo_flags_retransmit_cfg.sv
// Multi-queue FIFO core: per-queue flags, mark and retransmit, configuration registers.
//
// Contract
// - Full flag low blocks every write to the selected queue.
// - Full flag is registered on the write clock edge.
// - Up to four words written during full latency are stored, read before clearing.
// - Full flag works on word pairs; clearing needs two to six reads; here it counts single words.
// - Full flag reports the queue picked by the write queue select.
// - Empty flag low blocks every read from the selected queue.
// - Empty flag registered on read clock; released only by completed write pairs.
// - Empty flag reports the queue picked by the read queue select.
// - Retransmit reloads the queue read pointer with the marked location.
// - Mark records the location of the word valid on the output bus.
// - Retransmit acts on the queue picked by the read queue select.
// - After retransmit reads replay from mark, including later writes; flags follow.
// - Mark becomes frozen full limit until empty plus a delay, or reset.
// - Ten configuration registers, eight bits each.
// - Serial-load select low picks serial loading, high picks parallel loading.
// - Parallel mode with load low steps registers 0x1 to 0xA; load high is queues.
// - Parallel register access wraps to the first register after the last.
// - Registers read back only on the parallel output port.
// - A configuration change takes effect eight clock cycles after its write; here each new write restarts that count.
// - Register 0x3 low bits give one, two, four or eight queues.
// - Register 0xA bit 7 is the fast clock bit, set by default.
// - Reset clears pointers, full high, empty low, marks to default.
// - Output valid is active low and falls with each word read out.
`timescale 1ns/1ps
`default_nettype none

module multi_queue_fifo_flags_retransmit_cfg #(
  parameter int NUM_QUEUES = mq_fifo_pkg::NUM_QUEUES,
  parameter int QUEUE_DEPTH = mq_fifo_pkg::QUEUE_DEPTH,
  parameter int DATA_W = mq_fifo_pkg::DATA_W
) (
  // Clock and master reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Write side
  input wire logic write_enable_n,
  input wire logic [mq_fifo_pkg::QSEL_W-1:0] write_queue_select,
  input wire logic [DATA_W-1:0] data_in,
  output logic queue_full_n,
  // Read side
  input wire logic read_enable_n,
  input wire logic [mq_fifo_pkg::QSEL_W-1:0] read_queue_select,
  input wire logic mark,
  input wire logic retransmit_request,
  output logic [DATA_W-1:0] data_out,
  output logic output_valid_n,
  output logic [mq_fifo_pkg::QSEL_W-1:0] queue_valid,
  output logic queue_empty_n,
  // Configuration loading
  input wire logic serial_load_select,
  input wire logic config_load_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic fast_clock_mode
);

  localparam int AW = $clog2(QUEUE_DEPTH);
  localparam int PW = AW + 1;
  localparam int QW = mq_fifo_pkg::QSEL_W;
  localparam logic [PW-1:0] LVL_HARD = PW'(QUEUE_DEPTH);
  localparam logic [PW-1:0] LVL_SET = PW'(QUEUE_DEPTH - mq_fifo_pkg::FULL_GUARD_WORDS);
  localparam logic [PW-1:0] LVL_CLR = PW'(QUEUE_DEPTH - mq_fifo_pkg::FULL_GUARD_WORDS
                                          - mq_fifo_pkg::FULL_CLEAR_WORDS);
  localparam logic [mq_fifo_pkg::RELEASE_CNT_W-1:0] REL_LAST =
    mq_fifo_pkg::RELEASE_CNT_W'(mq_fifo_pkg::FULL_LIMIT_RELEASE_DELAY - 1);
  localparam logic [mq_fifo_pkg::APPLY_CNT_W-1:0] APPLY_LOAD =
    mq_fifo_pkg::APPLY_CNT_W'(mq_fifo_pkg::CFG_APPLY_CYCLES);
  localparam logic [mq_fifo_pkg::SER_CNT_W-1:0] SER_LAST =
    mq_fifo_pkg::SER_CNT_W'(mq_fifo_pkg::SER_FRAME_BITS - 1);

  // A select is valid only below the configured queue count.
  function automatic logic qsel_ok(input logic [QW-1:0] sel, input logic [2:0] qcnt);
    logic ok;
    ok = 1'b0;
    if (qcnt[mq_fifo_pkg::QCOUNT_BIT2]) begin
      ok = 1'b1;
    end else if (qcnt[mq_fifo_pkg::QCOUNT_BIT1]) begin
      ok = (sel < 3'h4);
    end else if (qcnt[mq_fifo_pkg::QCOUNT_BIT0]) begin
      ok = (sel < 3'h2);
    end else begin
      ok = (sel == 3'h0);
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic [DATA_W-1:0] mem_q [NUM_QUEUES][QUEUE_DEPTH];
  logic [PW-1:0] wr_ptr_q [NUM_QUEUES];
  logic [PW-1:0] wr_commit_q [NUM_QUEUES];
  logic [PW-1:0] rd_ptr_q [NUM_QUEUES];
  logic [PW-1:0] mark_ptr_q [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] limit_q;
  logic [NUM_QUEUES-1:0] full_st_q;
  logic [mq_fifo_pkg::RELEASE_CNT_W-1:0] rel_cnt_q [NUM_QUEUES];
  logic [PW-1:0] level [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] q_empty;

  logic full_n_q;
  logic empty_n_q;
  logic [DATA_W-1:0] data_out_q;
  logic out_valid_n_q;
  logic [QW-1:0] queue_valid_q;
  logic [PW-1:0] last_rd_ptr_q;
  logic rt_prev_q;

  logic [mq_fifo_pkg::CFG_W-1:0] cfg_q [mq_fifo_pkg::CFG_COUNT];
  logic [mq_fifo_pkg::CFG_IDX_W-1:0] par_widx_q;
  logic [mq_fifo_pkg::CFG_IDX_W-1:0] par_ridx_q;
  logic [2:0] qcount_act_q;
  logic fast_clk_q;
  logic [mq_fifo_pkg::APPLY_CNT_W-1:0] apply_cnt_q;
  logic sclk_prev_q;
  logic [mq_fifo_pkg::SER_FRAME_BITS-1:0] ser_sh_q;
  logic [mq_fifo_pkg::SER_CNT_W-1:0] ser_cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode.

  wire logic wq_ok = qsel_ok(write_queue_select, qcount_act_q);
  wire logic rq_ok = qsel_ok(read_queue_select, qcount_act_q);
  // The registered flag lags the level by two cycles, so the hard stop at a
  // completely used queue keeps words written in that gap from overwriting.
  wire logic wr_go = !write_enable_n && config_load_n && full_n_q && wq_ok
                     && (level[write_queue_select] != LVL_HARD);
  wire logic rd_go = !read_enable_n && config_load_n && empty_n_q && rq_ok
                     && !q_empty[read_queue_select];
  wire logic rt_go = retransmit_request && !rt_prev_q && rq_ok;
  wire logic mark_go = mark && !out_valid_n_q;

  wire logic par_mode = serial_load_select && !config_load_n;
  wire logic par_we = par_mode && !write_enable_n && read_enable_n;
  wire logic par_re = par_mode && !read_enable_n && write_enable_n;

  wire logic ser_mode = !serial_load_select && config_load_n;
  wire logic sclk_rise = ser_mode && serial_clock && !sclk_prev_q;
  wire logic [mq_fifo_pkg::SER_FRAME_BITS-1:0] ser_frame =
    {ser_sh_q[mq_fifo_pkg::SER_FRAME_BITS-2:0], serial_data_in};
  wire logic [7:0] ser_addr = ser_frame[15:8];
  wire logic ser_we = sclk_rise && (ser_cnt_q == SER_LAST)
                      && (ser_frame[23:16] == mq_fifo_pkg::SER_WRITE_CMD)
                      && (ser_addr >= {4'h0, mq_fifo_pkg::CFG_ADDR_FIRST})
                      && (ser_addr <= {4'h0, mq_fifo_pkg::CFG_ADDR_LAST});

  wire logic cfg_we = par_we || ser_we;
  wire logic [mq_fifo_pkg::CFG_IDX_W-1:0] cfg_widx =
    par_we ? par_widx_q : (ser_addr[3:0] - mq_fifo_pkg::CFG_ADDR_FIRST);
  wire logic [mq_fifo_pkg::CFG_W-1:0] cfg_wdata =
    par_we ? data_in[mq_fifo_pkg::CFG_W-1:0] : ser_frame[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Per-queue pointers, mark, frozen limit and full hysteresis.

  for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
    wire logic wr_this = wr_go && (write_queue_select == QW'(q));
    wire logic rd_this = rd_go && (read_queue_select == QW'(q));
    wire logic rt_this = rt_go && (read_queue_select == QW'(q));
    wire logic mk_this = mark_go && (queue_valid_q == QW'(q));

    // While the limit is frozen the fill level is measured from the mark.
    assign level[q] = wr_ptr_q[q] - (limit_q[q] ? mark_ptr_q[q] : rd_ptr_q[q]);
    // Reads only see words of completed write pairs.
    assign q_empty[q] = (rd_ptr_q[q] == wr_commit_q[q]);

    always_ff @(posedge ref_clk) begin
      if (wr_this) begin
        mem_q[q][wr_ptr_q[q][AW-1:0]] <= data_in;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        wr_ptr_q[q] <= '0;
        wr_commit_q[q] <= '0;
        rd_ptr_q[q] <= '0;
        mark_ptr_q[q] <= '0;
        limit_q[q] <= 1'b0;
        full_st_q[q] <= 1'b0;
        rel_cnt_q[q] <= '0;
      end else begin
        if (wr_this) begin
          wr_ptr_q[q] <= wr_ptr_q[q] + 1'b1;
          if (wr_ptr_q[q][0]) begin
            wr_commit_q[q] <= wr_ptr_q[q] + 1'b1;
          end
        end
        if (rt_this) begin
          rd_ptr_q[q] <= mark_ptr_q[q];
          limit_q[q] <= 1'b1;
        end else if (rd_this) begin
          rd_ptr_q[q] <= rd_ptr_q[q] + 1'b1;
        end
        if (mk_this) begin
          mark_ptr_q[q] <= last_rd_ptr_q;
        end
        if (level[q] >= LVL_SET) begin
          full_st_q[q] <= 1'b1;
        end else if (level[q] <= LVL_CLR) begin
          full_st_q[q] <= 1'b0;
        end
        if (limit_q[q] && q_empty[q] && !rt_this) begin
          rel_cnt_q[q] <= rel_cnt_q[q] + 1'b1;
          if (rel_cnt_q[q] == REL_LAST) begin
            limit_q[q] <= 1'b0;
            rel_cnt_q[q] <= '0;
          end
        end else begin
          rel_cnt_q[q] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and read data.

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      full_n_q <= 1'b1;
      empty_n_q <= 1'b0;
      rt_prev_q <= 1'b0;
    end else begin
      // An invalid select reads as full and empty so nothing moves.
      full_n_q <= wq_ok && !full_st_q[write_queue_select];
      empty_n_q <= rq_ok && !q_empty[read_queue_select];
      rt_prev_q <= retransmit_request;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      data_out_q <= '0;
      out_valid_n_q <= 1'b1;
      queue_valid_q <= '0;
      last_rd_ptr_q <= '0;
    end else if (rd_go) begin
      data_out_q <= mem_q[read_queue_select][rd_ptr_q[read_queue_select][AW-1:0]];
      out_valid_n_q <= 1'b0;
      queue_valid_q <= read_queue_select;
      last_rd_ptr_q <= rd_ptr_q[read_queue_select];
    end else if (par_re) begin
      data_out_q <= DATA_W'(cfg_q[par_ridx_q]);
      out_valid_n_q <= 1'b1;
    end else begin
      out_valid_n_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers, parallel and serial loading.

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < mq_fifo_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= mq_fifo_pkg::CFG_RESET[i];
      end
      par_widx_q <= '0;
      par_ridx_q <= '0;
    end else begin
      if (cfg_we) begin
        cfg_q[cfg_widx] <= cfg_wdata;
      end
      if (par_we) begin
        par_widx_q <= (par_widx_q == mq_fifo_pkg::CFG_IDX_LAST) ? '0
                      : par_widx_q + 1'b1;
      end
      if (par_re) begin
        par_ridx_q <= (par_ridx_q == mq_fifo_pkg::CFG_IDX_LAST) ? '0
                      : par_ridx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !ser_mode) begin
      sclk_prev_q <= 1'b0;
      ser_sh_q <= '0;
      ser_cnt_q <= '0;
    end else begin
      sclk_prev_q <= serial_clock;
      if (sclk_rise) begin
        ser_sh_q <= ser_frame;
        ser_cnt_q <= (ser_cnt_q == SER_LAST) ? '0 : ser_cnt_q + 1'b1;
      end
    end
  end

  // The queue logic sees new settings only after the settling delay, so a
  // write never changes queue decoding under an access in flight.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      apply_cnt_q <= '0;
      qcount_act_q <= mq_fifo_pkg::QCOUNT_RESET;
      fast_clk_q <= mq_fifo_pkg::CFG_RESET[mq_fifo_pkg::CFG_FAST_IDX][mq_fifo_pkg::FAST_CLK_BIT];
    end else if (cfg_we) begin
      apply_cnt_q <= APPLY_LOAD;
    end else if (apply_cnt_q != '0) begin
      apply_cnt_q <= apply_cnt_q - 1'b1;
      if (apply_cnt_q == 4'h1) begin
        qcount_act_q <= cfg_q[mq_fifo_pkg::CFG_QCOUNT_IDX][2:0];
        fast_clk_q <= cfg_q[mq_fifo_pkg::CFG_FAST_IDX][mq_fifo_pkg::FAST_CLK_BIT];
      end
    end
  end

  assign queue_full_n = full_n_q;
  assign queue_empty_n = empty_n_q;
  assign data_out = data_out_q;
  assign output_valid_n = out_valid_n_q;
  assign queue_valid = queue_valid_q;
  assign fast_clock_mode = fast_clk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_full_blocks_write;
    !full_n_q |=> wr_ptr_q[$past(write_queue_select)] == $past(wr_ptr_q[write_queue_select]);
  endproperty
  a_full_blocks_write: assert property (p_full_blocks_write) else $error("write while full");

  property p_empty_blocks_read;
    !empty_n_q && !read_enable_n && config_load_n |=> out_valid_n_q;
  endproperty
  a_empty_blocks_read: assert property (p_empty_blocks_read) else $error("read while empty");

  property p_full_tracks_select;
    ##1 ((full_n_q == (qsel_ok($past(write_queue_select), qcount_act_q)
                       && !$past(full_st_q[write_queue_select])))
      || $changed(qcount_act_q));
  endproperty
  a_full_tracks_select: assert property (p_full_tracks_select) else $error("full flag source");

  property p_full_clears_low;
    full_st_q[write_queue_select] && level[write_queue_select] <= LVL_CLR
      && !$rose(full_st_q[write_queue_select]) |=> !full_st_q[$past(write_queue_select)];
  endproperty
  a_full_clears_low: assert property (p_full_clears_low) else $error("full did not clear");

  property p_retransmit_reload;
    rt_go |=>
      rd_ptr_q[$past(read_queue_select)] == $past(mark_ptr_q[read_queue_select])
      && limit_q[$past(read_queue_select)];
  endproperty
  a_retransmit_reload: assert property (p_retransmit_reload) else $error("no reload");

  property p_valid_with_read;
    rd_go |=> !out_valid_n_q && queue_valid_q == $past(read_queue_select);
  endproperty
  a_valid_with_read: assert property (p_valid_with_read) else $error("valid missing");

  property p_cfg_wrap;
    par_we && par_widx_q == mq_fifo_pkg::CFG_IDX_LAST |=> par_widx_q == '0;
  endproperty
  a_cfg_wrap: assert property (p_cfg_wrap) else $error("no wrap");

  property p_cfg_apply;
    cfg_we && cfg_widx == mq_fifo_pkg::CFG_QCOUNT_IDX ##1 !cfg_we [*8]
      |=> qcount_act_q == $past(cfg_q[mq_fifo_pkg::CFG_QCOUNT_IDX][2:0]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("late apply");

  property p_cfg_not_early;
    cfg_we |=> $stable(qcount_act_q) [*7];
  endproperty
  a_cfg_not_early: assert property (p_cfg_not_early) else $error("early apply");

  property p_limit_holds;
    limit_q[read_queue_select] && !q_empty[read_queue_select]
      && $stable(read_queue_select) |=> limit_q[$past(read_queue_select)];
  endproperty
  a_limit_holds: assert property (p_limit_holds) else $error("limit lost");

  property p_mark_records;
    mark_go |=> mark_ptr_q[$past(queue_valid_q)] == $past(last_rd_ptr_q);
  endproperty
  a_mark_records: assert property (p_mark_records) else $error("mark wrong");

  c_full_seen: cover property (!full_n_q ##[1:40] full_n_q);
  c_retransmit: cover property (rt_go ##[1:20] rd_go);
  c_limit_release: cover property ($fell(limit_q[read_queue_select]));
  c_serial_write: cover property (ser_we);

endmodule // multi_queue_fifo_flags_retransmit_cfg

`default_nettype wire

// >>> dv/serial_loader_model.sv
// Model of the controller that loads configuration registers over the serial path.
`timescale 1ns/1ps
`default_nettype none

module serial_loader_model (
  // Clock
  input wire logic ref_clk,
  // Serial loading lines
  output logic serial_clock,
  output logic serial_data_in
);
  initial begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One write frame, command then address then data, most significant bit first.
  // The shift clock rests low between frames, and the data line is flipped after the
  // last bit so that a late sample never sees a stale but plausible value.
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    logic [23:0] frame;
    frame = {mq_fifo_pkg::SER_WRITE_CMD, addr, data};
    for (int i = 23; i >= 0; i--) begin
      @(posedge ref_clk);
      serial_data_in <= frame[i];
      serial_clock <= 1'b0;
      repeat (2) @(posedge ref_clk);
      serial_clock <= 1'b1;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    serial_clock <= 1'b0;
    serial_data_in <= ~frame[0];
  endtask
endmodule // serial_loader_model

`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the multi-queue flag, retransmit and configuration core.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_enable_n = 1'b1;
  logic [2:0] write_queue_select = 3'h0;
  logic [35:0] data_in = 36'h0;
  logic read_enable_n = 1'b1;
  logic [2:0] read_queue_select = 3'h0;
  logic mark = 1'b0;
  logic retransmit_request = 1'b0;
  logic serial_load_select = 1'b1;
  logic config_load_n = 1'b1;
  wire logic serial_clock;
  wire logic serial_data_in;
  wire logic queue_full_n;
  wire logic [35:0] data_out;
  wire logic output_valid_n;
  wire logic [2:0] queue_valid;
  wire logic queue_empty_n;
  wire logic fast_clock_mode;
  int err_total = 0;
  int total_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  multi_queue_fifo_flags_retransmit_cfg dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .write_enable_n(write_enable_n),
    .write_queue_select(write_queue_select), .data_in(data_in),
    .queue_full_n(queue_full_n), .read_enable_n(read_enable_n),
    .read_queue_select(read_queue_select), .mark(mark),
    .retransmit_request(retransmit_request), .data_out(data_out),
    .output_valid_n(output_valid_n), .queue_valid(queue_valid),
    .queue_empty_n(queue_empty_n), .serial_load_select(serial_load_select),
    .config_load_n(config_load_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .fast_clock_mode(fast_clock_mode)
  );

  serial_loader_model partner (
    .ref_clk(ref_clk), .serial_clock(serial_clock), .serial_data_in(serial_data_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] cfg_val(input int k);
    return (k == 9) ? 8'h29 : 8'hA0 + 8'(k);
  endfunction

  task automatic do_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    config_load_n <= 1'b1;
    serial_load_select <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask

  // Writes go out back to back, so every pair commits inside the burst.
  task automatic write_burst(input logic [2:0] q, input logic [35:0] base, input int n);
    @(posedge ref_clk);
    write_queue_select <= q;
    write_enable_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      data_in <= base + 36'(i);
      @(posedge ref_clk);
    end
    write_enable_n <= 1'b1;
  endtask

  // A single read; mk raises mark while the word is valid on the output.
  task automatic read_one(input logic [35:0] exp, input logic [2:0] q, input logic mk);
    @(posedge ref_clk);
    read_enable_n <= 1'b0;
    mark <= 1'b0;
    @(posedge ref_clk);
    read_enable_n <= 1'b1;
    mark <= mk;
    #1;
    chk(data_out, exp);
    chk(output_valid_n, 1'b0);
    chk(queue_valid, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    do_reset;
    @(posedge ref_clk);
    #1;
    chk(queue_full_n, 1'b1);
    chk(queue_empty_n, 1'b0);
    chk(output_valid_n, 1'b1);
    chk(data_out, 36'h0);
    chk(fast_clock_mode, 1'b1);
    $display("reset test done");
  endtask

  task automatic t_pairs;
    do_reset;
    read_queue_select <= 3'h3;
    write_burst(3'h3, 36'hA5, 1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b0);
    @(posedge ref_clk);
    read_enable_n <= 1'b0;
    @(posedge ref_clk);
    read_enable_n <= 1'b1;
    #1;
    chk(output_valid_n, 1'b1);
    write_burst(3'h3, 36'hA6, 1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b1);
    @(posedge ref_clk);
    read_queue_select <= 3'h4;
    @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b0);
    @(posedge ref_clk);
    read_queue_select <= 3'h3;
    @(posedge ref_clk);
    read_one(36'hA5, 3'h3, 1'b0);
    read_one(36'hA6, 3'h3, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b0);
    $display("pair test done");
  endtask

  task automatic t_full;
    int n;
    int clr;
    n = 0;
    clr = 0;
    do_reset;
    read_queue_select <= 3'h0;
    write_burst(3'h0, 36'h100, 20);
    #1;
    chk(queue_full_n, 1'b0);
    @(posedge ref_clk);
    write_queue_select <= 3'h1;
    @(posedge ref_clk);
    write_queue_select <= 3'h0;
    #1;
    chk(queue_full_n, 1'b1);
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 24 && queue_empty_n === 1'b1; i++) begin
      read_one(36'h100 + 36'(n), 3'h0, 1'b0);
      n++;
      @(posedge ref_clk);
      #1;
      if (clr == 0 && queue_full_n === 1'b1) clr = n;
    end
    if (queue_empty_n !== 1'b0) begin
      err_total++;
      results;
    end
    chk(clr >= 2 && clr <= 6, 1'b1);
    chk(n > 12 && n <= mq_fifo_pkg::QUEUE_DEPTH, 1'b1);
    $display("full test done");
  endtask

  task automatic t_retx;
    do_reset;
    read_queue_select <= 3'h1;
    write_burst(3'h1, 36'h200, 4);
    repeat (2) @(posedge ref_clk);
    read_one(36'h200, 3'h1, 1'b1);
    for (int i = 1; i < 4; i++) read_one(36'h200 + 36'(i), 3'h1, 1'b0);
    repeat (4) @(posedge ref_clk);
    @(posedge ref_clk);
    retransmit_request <= 1'b1;
    @(posedge ref_clk);
    retransmit_request <= 1'b0;
    write_burst(3'h1, 36'h204, 2);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b1);
    for (int i = 0; i < 2; i++) read_one(36'h200 + 36'(i), 3'h1, 1'b0);
    // Two replayed reads must not lower the level while the limit is frozen.
    write_burst(3'h1, 36'h206, 6);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(queue_full_n, 1'b0);
    for (int i = 2; i < 12; i++) read_one(36'h200 + 36'(i), 3'h1, 1'b0);
    chk(queue_full_n, 1'b0);
    repeat (8) @(posedge ref_clk);
    #1;
    chk(queue_full_n, 1'b1);
    $display("retransmit test done");
  endtask

  task automatic t_cfg_par;
    do_reset;
    write_burst(3'h4, 36'h400, 2);
    config_load_n <= 1'b0;
    @(posedge ref_clk);
    read_enable_n <= 1'b0;
    for (int k = 0; k < 11; k++) begin
      @(posedge ref_clk);
      if (k == 10) read_enable_n <= 1'b1;
      #1;
      chk(data_out, {28'h0, mq_fifo_pkg::CFG_RESET[k % 10]});
    end
    @(posedge ref_clk);
    write_enable_n <= 1'b0;
    data_in <= {28'h0, cfg_val(0)};
    for (int k = 1; k < 10; k++) begin
      @(posedge ref_clk);
      data_in <= {28'h0, cfg_val(k)};
    end
    @(posedge ref_clk);
    write_enable_n <= 1'b1;
    for (int j = 1; j <= 8; j++) begin
      @(posedge ref_clk);
      #1;
      chk(fast_clock_mode, j < 8);
    end
    @(posedge ref_clk);
    config_load_n <= 1'b1;
    read_queue_select <= 3'h4;
    write_queue_select <= 3'h4;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b0);
    chk(queue_full_n, 1'b0);
    @(posedge ref_clk);
    write_queue_select <= 3'h3;
    @(posedge ref_clk);
    #1;
    chk(queue_full_n, 1'b1);
    @(posedge ref_clk);
    config_load_n <= 1'b0;
    read_enable_n <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      @(posedge ref_clk);
      if (k == 9) read_enable_n <= 1'b1;
      #1;
      chk(data_out, {28'h0, cfg_val((k + 1) % 10)});
    end
    $display("parallel config test done");
  endtask

  // Queue 2 holds a pair, so both flags drop only once two-queue mode applies.
  task automatic t_serial;
    do_reset;
    write_burst(3'h2, 36'h300, 2);
    read_queue_select <= 3'h2;
    serial_load_select <= 1'b0;
    partner.send(8'h03, 8'h01);
    @(posedge ref_clk);
    serial_load_select <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(queue_full_n, 1'b1);
    chk(queue_empty_n, 1'b1);
    repeat (6) @(posedge ref_clk);
    #1;
    chk(queue_empty_n, 1'b0);
    chk(queue_full_n, 1'b0);
    @(posedge ref_clk);
    config_load_n <= 1'b0;
    read_enable_n <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      if (k == 2) read_enable_n <= 1'b1;
    end
    #1;
    chk(data_out, 36'h1);
    $display("serial config test done");
  endtask

  initial begin
    t_reset;
    t_pairs;
    t_full;
    t_retx;
    t_cfg_par;
    t_serial;
    results;
  end
endmodule // testbench

`default_nettype wire
